/* File: inc/tbp_defs.vh */
// register offsets, field positions, reset values and the external clock select for the buffered compare and pwm timer
`ifndef TBP_DEFS_VH
`define TBP_DEFS_VH

`define TBP_ADDR_W        4
`define TBP_TIMER_CTL     4'h0
`define TBP_COUNT_HIGH    4'h1
`define TBP_COUNT_LOW     4'h2
`define TBP_MODULO_HIGH   4'h3
`define TBP_MODULO_LOW    4'h4
`define TBP_CH0_CTL       4'h5
`define TBP_CH_STRIDE     4'h3
`define TBP_CH_VAL_HIGH   4'h1
`define TBP_CH_VAL_LOW    4'h2

`define TBP_TC_WRAP_FLAG  7
`define TBP_TC_WRAP_IE    6
`define TBP_TC_HALT       5
`define TBP_TC_CLEAR      4
`define TBP_TC_RESET      8'h20

`define TBP_CC_FLAG       7
`define TBP_CC_IE         6
`define TBP_CC_MODE_HIGH  5
`define TBP_CC_MODE_LOW   4
`define TBP_CC_ACT_HIGH   3
`define TBP_CC_ACT_LOW    2
`define TBP_CC_TOGGLE     1
`define TBP_CC_FULL       0
`define TBP_CC_RESET      8'h00

`define TBP_MODULO_RESET  16'hFFFF
`define TBP_VAL_RESET     16'h0000
`define TBP_SEL_EXT       3'h7

`endif

/* File: rtl/tbp_prescaler.v */
// timer clock prescaler: bus clock divided by 1..64 or the synchronised external clock pin
`timescale 1ns/1ps
`default_nettype none
`include "tbp_defs.vh"

module tbp_prescaler (
  input  wire       mclk_i,
  input  wire       rst_i,
  input  wire       clear_i,
  input  wire       halt_i,
  input  wire [2:0] sel_i,
  input  wire       ext_clk_i,
  output wire       tick_o
);

  reg  [5:0] div_q;
  reg        ext_s1_q;
  reg        ext_s2_q;
  reg        ext_s3_q;
  reg  [5:0] mask;
  wire       ext_rise;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_clk_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_rise = ext_s2_q & ~ext_s3_q;

  always @* begin
    case (sel_i)
      3'h0:    mask = 6'h00;
      3'h1:    mask = 6'h01;
      3'h2:    mask = 6'h03;
      3'h3:    mask = 6'h07;
      3'h4:    mask = 6'h0F;
      3'h5:    mask = 6'h1F;
      default: mask = 6'h3F;
    endcase
  end

  // divider holds its count under halt so the phase is kept; clear restarts it
  always @(posedge mclk_i) begin
    if (rst_i || clear_i) begin
      div_q <= 6'h00;
    end else if (!halt_i) begin
      div_q <= div_q + 6'h01;
    end
  end

  assign tick_o = ~halt_i & ~clear_i &
                  ((sel_i == `TBP_SEL_EXT) ? ext_rise : ((div_q & mask) == mask));

endmodule // tbp_prescaler
`default_nettype wire

/* File: rtl/tbp_timer.v */
// two-channel 16-bit timer with output compare, buffered pair and pwm
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tbp_defs.vh"

module tbp_timer #(
  parameter NCH = 2
) (
  input  wire                   mclk_i,
  input  wire                   rst_i,
  input  wire [`TBP_ADDR_W-1:0] addr_i,
  input  wire [7:0]             wdata_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output reg  [7:0]             rdata_o,
  input  wire                   wait_i,
  input  wire                   external_timer_clock_i,
  input  wire [NCH-1:0]         chan_pin_i,
  output wire [NCH-1:0]         chan_pin_o,
  output wire [NCH-1:0]         chan_pin_oe_o,
  output wire                   irq_o
);

  // registers are closed to the processor while waiting
  wire wr = wr_i & ~wait_i;
  wire rd = rd_i & ~wait_i;

  reg  [7:0]  tc_q;
  reg         wrap_flag_q;
  reg         wrap_arm_q;
  reg  [15:0] count_q;
  reg  [7:0]  count_lo_latch_q;
  reg         count_latched_q;
  reg  [15:0] modulo_q;
  reg         modulo_hold_q;
  reg         active_q;
  reg         last_q;
  reg         link_d1_q;
  reg  [7:0]  rdata_d;

  wire [8*NCH-1:0]  ctl_w;
  wire [16*NCH-1:0] val_w;
  wire [NCH-1:0]    val_wr_w;
  wire [NCH-1:0]    ch_irq_w;

  wire        clear_pulse = wr && (addr_i == `TBP_TIMER_CTL) && wdata_i[`TBP_TC_CLEAR];
  wire        halt = tc_q[`TBP_TC_HALT];
  wire        tick;
  wire        at_modulo = (count_q == modulo_q);
  wire        wrap_ev = tick & at_modulo;
  // compares look at the value the counter is about to take, so a width of n spans n ticks after the wrap
  wire [15:0] count_nx = wrap_ev ? 16'h0000 : count_q + 16'h0001;
  wire        link = ctl_w[`TBP_CC_MODE_HIGH];

  tbp_prescaler u_pre (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .clear_i   (clear_pulse),
    .halt_i    (halt),
    .sel_i     (tc_q[2:0]),
    .ext_clk_i (external_timer_clock_i),
    .tick_o    (tick)
  );

  // counter and timer control
  always @(posedge mclk_i) begin
    if (rst_i) begin
      count_q <= 16'h0000;
    end else if (clear_pulse) begin
      count_q <= 16'h0000;
    end else if (wrap_ev) begin
      count_q <= 16'h0000;
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      tc_q          <= `TBP_TC_RESET;
      wrap_flag_q   <= 1'b0;
      wrap_arm_q    <= 1'b0;
      modulo_q      <= `TBP_MODULO_RESET;
      modulo_hold_q <= 1'b0;
    end else begin
      if (wr && (addr_i == `TBP_TIMER_CTL)) begin
        tc_q <= {2'b00, wdata_i[5], 1'b0, 1'b0, wdata_i[2:0]} | {1'b0, wdata_i[6], 6'h00};
      end
      if (wr && (addr_i == `TBP_MODULO_HIGH)) begin
        modulo_q[15:8] <= wdata_i;
        modulo_hold_q  <= 1'b1;
      end
      if (wr && (addr_i == `TBP_MODULO_LOW)) begin
        modulo_q[7:0] <= wdata_i;
        modulo_hold_q <= 1'b0;
      end
      // a new wrap wins over a pending clear and disarms it
      if (wrap_ev && !modulo_hold_q) begin
        wrap_flag_q <= 1'b1;
        wrap_arm_q  <= 1'b0;
      end else begin
        if (rd && (addr_i == `TBP_TIMER_CTL) && wrap_flag_q) begin
          wrap_arm_q <= 1'b1;
        end
        if (wr && (addr_i == `TBP_TIMER_CTL) && !wdata_i[`TBP_TC_WRAP_FLAG] && wrap_arm_q) begin
          wrap_flag_q <= 1'b0;
          wrap_arm_q  <= 1'b0;
        end
      end
    end
  end

  // linked pair selection
  always @(posedge mclk_i) begin
    if (rst_i) begin
      active_q  <= 1'b0;
      last_q    <= 1'b0;
      link_d1_q <= 1'b0;
    end else begin
      link_d1_q <= link;
      if (link && !link_d1_q) begin
        active_q <= 1'b0;
        last_q   <= 1'b0;
      end else begin
        if (val_wr_w[1]) begin
          last_q <= 1'b1;
        end else if (val_wr_w[0]) begin
          last_q <= 1'b0;
        end
        if (wrap_ev) begin
          active_q <= val_wr_w[1] ? 1'b1 : (val_wr_w[0] ? 1'b0 : last_q);
        end
      end
    end
  end

  wire [15:0] ch0_cmp_val = (link && active_q) ? val_w[31:16] : val_w[15:0];

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
      localparam integer           CTL_N = `TBP_CH0_CTL + gi * `TBP_CH_STRIDE;
      localparam [`TBP_ADDR_W-1:0] CTL_A = CTL_N[`TBP_ADDR_W-1:0];
      localparam [`TBP_ADDR_W-1:0] HI_A  = CTL_A + `TBP_CH_VAL_HIGH;
      localparam [`TBP_ADDR_W-1:0] LO_A  = CTL_A + `TBP_CH_VAL_LOW;

      reg  [7:0]  ctl_q;
      reg  [15:0] val_q;
      reg         arm_q;
      reg         out_q;
      reg         cmp_hold_q;
      reg         pin_s1_q;
      reg         pin_s2_q;
      reg         pin_s3_q;
      reg         nx;

      // channel 1 stands idle while linked; channel 0 control governs
      wire        en     = (gi == 0) | ~link;
      wire        oc     = en & (ctl_q[`TBP_CC_MODE_HIGH] | ctl_q[`TBP_CC_MODE_LOW]);
      wire [1:0]  act    = ctl_q[`TBP_CC_ACT_HIGH:`TBP_CC_ACT_LOW];
      wire        tov    = ctl_q[`TBP_CC_TOGGLE];
      wire        full   = ctl_q[`TBP_CC_FULL];
      wire [15:0] cmp_v  = (gi == 0) ? ch0_cmp_val : val_q;
      wire        cmp_ev = oc & tick & ~cmp_hold_q & (count_nx == cmp_v);
      wire        rise   = pin_s2_q & ~pin_s3_q;
      wire        fall   = ~pin_s2_q & pin_s3_q;
      wire        cap_ev = en & ~oc & ((act[0] & rise) | (act[1] & fall));
      wire        ev     = cmp_ev | cap_ev;

      always @(posedge mclk_i) begin
        if (rst_i) begin
          pin_s1_q <= 1'b0;
          pin_s2_q <= 1'b0;
          pin_s3_q <= 1'b0;
        end else begin
          pin_s1_q <= chan_pin_i[gi];
          pin_s2_q <= pin_s1_q;
          pin_s3_q <= pin_s2_q;
        end
      end

      always @(posedge mclk_i) begin
        if (rst_i) begin
          ctl_q      <= `TBP_CC_RESET;
          val_q      <= `TBP_VAL_RESET;
          arm_q      <= 1'b0;
          cmp_hold_q <= 1'b0;
        end else begin
          if (wr && (addr_i == CTL_A)) begin
            ctl_q[6:0] <= wdata_i[6:0];
          end
          // high byte write holds compares until the low byte completes the value
          if (wr && (addr_i == HI_A)) begin
            val_q[15:8] <= wdata_i;
            cmp_hold_q  <= 1'b1;
          end
          if (wr && (addr_i == LO_A)) begin
            val_q[7:0] <= wdata_i;
            cmp_hold_q <= 1'b0;
          end
          if (cap_ev) begin
            val_q <= count_q;
          end
          if (ev) begin
            ctl_q[`TBP_CC_FLAG] <= 1'b1;
            arm_q <= 1'b0;
          end else begin
            if (rd && (addr_i == CTL_A) && ctl_q[`TBP_CC_FLAG]) begin
              arm_q <= 1'b1;
            end
            if (wr && (addr_i == CTL_A) && !wdata_i[`TBP_CC_FLAG] && arm_q) begin
              ctl_q[`TBP_CC_FLAG] <= 1'b0;
              arm_q <= 1'b0;
            end
          end
        end
      end

      always @* begin
        nx = out_q;
        if (wrap_ev && tov) begin
          nx = ~nx;
        end
        if (cmp_ev) begin
          case (act)
            2'b01:   nx = ~nx;
            2'b10:   nx = 1'b0;
            2'b11:   nx = 1'b1;
            default: nx = nx;
          endcase
        end
        if (full && tov) begin
          nx = ~act[0];
        end
      end

      always @(posedge mclk_i) begin
        if (rst_i) begin
          out_q <= 1'b0;
        end else if (oc) begin
          out_q <= nx;
        end
      end

      assign ctl_w[8*gi+:8]   = ctl_q;
      assign val_w[16*gi+:16] = val_q;
      assign val_wr_w[gi]     = wr && ((addr_i == HI_A) || (addr_i == LO_A));
      assign chan_pin_o[gi]    = out_q;
      assign chan_pin_oe_o[gi] = oc & (act != 2'b00);
      assign ch_irq_w[gi]     = ctl_q[`TBP_CC_FLAG] & ctl_q[`TBP_CC_IE] & en;
    end
  endgenerate

  // enabled requests stay live in wait so they can end it
  assign irq_o = (wrap_flag_q & tc_q[`TBP_TC_WRAP_IE]) | (|ch_irq_w);

  // reading the high count byte freezes the low byte until it is read
  always @(posedge mclk_i) begin
    if (rst_i) begin
      count_lo_latch_q <= 8'h00;
      count_latched_q  <= 1'b0;
    end else if (rd && (addr_i == `TBP_COUNT_HIGH) && !count_latched_q) begin
      count_lo_latch_q <= count_q[7:0];
      count_latched_q  <= 1'b1;
    end else if (rd && (addr_i == `TBP_COUNT_LOW)) begin
      count_latched_q <= 1'b0;
    end
  end

  always @* begin
    case (addr_i)
      `TBP_TIMER_CTL:   rdata_d = {wrap_flag_q, tc_q[6:5], 1'b0, 1'b0, tc_q[2:0]};
      `TBP_COUNT_HIGH:  rdata_d = count_q[15:8];
      `TBP_COUNT_LOW:   rdata_d = count_latched_q ? count_lo_latch_q : count_q[7:0];
      `TBP_MODULO_HIGH: rdata_d = modulo_q[15:8];
      `TBP_MODULO_LOW:  rdata_d = modulo_q[7:0];
      4'h5:             rdata_d = ctl_w[7:0];
      4'h6:             rdata_d = val_w[15:8];
      4'h7:             rdata_d = val_w[7:0];
      4'h8:             rdata_d = {ctl_w[15:14], 1'b0, ctl_w[12:8]};
      4'h9:             rdata_d = val_w[31:24];
      4'hA:             rdata_d = val_w[23:16];
      default:          rdata_d = 8'h00;
    endcase
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd) begin
      rdata_o <= rdata_d;
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // tbp_timer
`default_nettype wire

/* File: verification/tbp_timer_asserts.sv */
// port checker for the buffered compare and pwm timer
`timescale 1ns/1ps
`default_nettype none

module tbp_timer_asserts #(
  parameter NCH = 2
) (
  input wire logic           mclk_i,
  input wire logic           rst_i,
  input wire logic [3:0]     addr_i,
  input wire logic [7:0]     wdata_i,
  input wire logic           wr_i,
  input wire logic           rd_i,
  input wire logic [7:0]     rdata_o,
  input wire logic           wait_i,
  input wire logic           external_timer_clock_i,
  input wire logic [NCH-1:0] chan_pin_i,
  input wire logic [NCH-1:0] chan_pin_o,
  input wire logic [NCH-1:0] chan_pin_oe_o,
  input wire logic           irq_o
);
  logic [7:0] c0_q;
  logic [7:0] mlo_q;
  logic       ie_q;
  logic       c1_q;

  // shadows of written bits, so outputs can be tied to their cause
  always @(posedge mclk_i) begin
    if (rst_i) begin
      c0_q  <= 8'h00;
      mlo_q <= 8'hFF;
      ie_q  <= 1'b0;
      c1_q  <= 1'b0;
    end else if (wr_i && !wait_i) begin
      case (addr_i)
        4'h0: ie_q <= wdata_i[6];
        4'h4: mlo_q <= wdata_i;
        4'h5: c0_q <= wdata_i;
        4'h8: c1_q <= wdata_i[6];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_rd_only; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
  a_rd_only: assert property (p_rd_only) else $error("read data outside read slot");
  property p_wait_rd; wait_i && rd_i |=> rdata_o == 8'h00; endproperty
  a_wait_rd: assert property (p_wait_rd) else $error("read answered in wait");
  property p_clr_rd; rd_i && !wait_i && addr_i == 4'h0 |=> !rdata_o[4]; endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("counter clear bit read as one");
  property p_c1_rd; rd_i && !wait_i && addr_i == 4'h8 |=> !rdata_o[5]; endproperty
  a_c1_rd: assert property (p_c1_rd) else $error("channel 1 link bit read as one");
  property p_link; c0_q[5] |-> !chan_pin_oe_o[1]; endproperty
  a_link: assert property (p_link) else $error("channel 1 pin driven while linked");
  property p_irq; !ie_q && !c0_q[6] && !c1_q |-> !irq_o; endproperty
  a_irq: assert property (p_irq) else $error("request with all enables off");
  property p_mod; rd_i && !wait_i && addr_i == 4'h4 |=> rdata_o == $past(mlo_q); endproperty
  a_mod: assert property (p_mod) else $error("modulo low readback wrong");
  property p_full; c0_q[5:0] == 6'h1B && $past(c0_q[5:0], 8) == 6'h1B |-> chan_pin_o[0]; endproperty
  a_full: assert property (p_full) else $error("full duty pin not high");

  c_wait: cover property (wait_i && rd_i);
  c_link: cover property (c0_q[5] && chan_pin_oe_o[0]);
  c_irq: cover property (irq_o);
endmodule  // tbp_timer_asserts

bind tbp_timer tbp_timer_asserts #(.NCH(NCH)) u_chk (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .wait_i, .external_timer_clock_i, .chan_pin_i, .chan_pin_o, .chan_pin_oe_o, .irq_o);

`default_nettype wire

/* File: verification/tbp_load.sv */
// load on the channel pins: resolves pin levels and measures ch0 pulses
`timescale 1ns/1ps
`default_nettype none

module tbp_load (
  input  wire logic        mclk_i,
  input  wire logic [1:0]  pin_o_i,
  input  wire logic [1:0]  pin_oe_i,
  output wire logic [1:0]  pin_lvl_o,
  output var  logic [15:0] period_o,
  output var  logic [15:0] high_o
);
  logic [1:0]  last_q = 2'b00;
  logic [1:0]  drv_q = 2'b00;
  logic [15:0] cyc_q = 16'h0000;
  logic [15:0] hc_q = 16'h0000;

  initial period_o = 16'h0000;
  initial high_o = 16'h0000;

  // a released pin shows the inverse of the level last driven, never a stale value
  assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ~drv_q);

  always @(posedge mclk_i) begin
    last_q <= pin_lvl_o;
    drv_q  <= (pin_oe_i & pin_o_i) | (~pin_oe_i & drv_q);
    if (pin_lvl_o[0] && !last_q[0]) begin
      period_o <= cyc_q;
      cyc_q    <= 16'h0001;
    end else begin
      cyc_q <= cyc_q + 16'h0001;
    end
    if (pin_lvl_o[0]) begin
      hc_q <= hc_q + 16'h0001;
    end else if (last_q[0]) begin
      high_o <= hc_q;
      hc_q   <= 16'h0000;
    end
  end
endmodule  // tbp_load

`default_nettype wire

/* File: verification/timer_buffered_compare_pwm_tb.sv */
// self-checking bench for the buffered compare and pwm timer
`timescale 1ns/1ps
`default_nettype none

module timer_buffered_compare_pwm_tb;
  typedef struct packed {
    logic [2:0]  ps;
    logic [7:0]  md;
    logic [7:0]  vl;
    logic        act;
    logic [15:0] per;
    logic [15:0] hi;
  } tbp_row_t;

  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  addr_i = 4'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        wait_i = 1'b0;
  logic        ext_clk = 1'b0;
  wire  [7:0]  rdata_o;
  wire  [1:0]  pin_lvl;
  wire  [1:0]  pin_o;
  wire  [1:0]  pin_oe;
  wire         irq_o;
  wire  [15:0] period;
  wire  [15:0] high;
  logic [15:0] v;
  int          n;
  int          n_mismatch = 0;
  int          checks = 0;
  // external clock runs at one eighth of the bus clock
  tbp_row_t    rows [10] = '{
    '{3'h0, 8'hFF, 8'h80, 1'b0, 16'h0100, 16'h0080},
    '{3'h0, 8'h09, 8'h03, 1'b0, 16'h000A, 16'h0003},
    '{3'h0, 8'h0F, 8'h05, 1'b1, 16'h0010, 16'h000B},
    '{3'h1, 8'h03, 8'h01, 1'b0, 16'h0008, 16'h0002},
    '{3'h2, 8'h03, 8'h01, 1'b0, 16'h0010, 16'h0004},
    '{3'h3, 8'h03, 8'h01, 1'b0, 16'h0020, 16'h0008},
    '{3'h4, 8'h03, 8'h01, 1'b0, 16'h0040, 16'h0010},
    '{3'h5, 8'h03, 8'h01, 1'b0, 16'h0080, 16'h0020},
    '{3'h6, 8'h03, 8'h01, 1'b0, 16'h0100, 16'h0040},
    '{3'h7, 8'h03, 8'h01, 1'b0, 16'h0020, 16'h0008}};

  tbp_timer uut (
    .mclk_i                 (mclk_i),
    .rst_i                  (rst_i),
    .addr_i                 (addr_i),
    .wdata_i                (wdata_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .rdata_o                (rdata_o),
    .wait_i                 (wait_i),
    .external_timer_clock_i (ext_clk),
    .chan_pin_i             (pin_lvl),
    .chan_pin_o             (pin_o),
    .chan_pin_oe_o          (pin_oe),
    .irq_o                  (irq_o)
  );

  tbp_load u_load (
    .mclk_i    (mclk_i),
    .pin_o_i   (pin_o),
    .pin_oe_i  (pin_oe),
    .pin_lvl_o (pin_lvl),
    .period_o  (period),
    .high_o    (high)
  );

  initial begin
    forever #10 mclk_i = ~mclk_i;
  end

  initial begin
    #3;
    forever #80 ext_clk = ~ext_clk;
  end

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = {8'h00, rdata_o};
  endtask

  task automatic do_reset;
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
  endtask

  // halt, clear, modulo, value, mode, then run
  task automatic pwm(input logic [7:0] md, input logic [7:0] vl, input logic [7:0] ctl, input logic [2:0] ps);
    do_reset;
    wr(4'h0, 8'h30);
    wr(4'h3, 8'h00);
    wr(4'h4, md);
    wr(4'h6, 8'h00);
    wr(4'h7, vl);
    wr(4'h5, ctl);
    wr(4'h0, {5'h00, ps});
  endtask

  task automatic hi_count;
    n = 0;
    repeat (64) begin
      @(negedge mclk_i);
      if (pin_o[0] === 1'b1) n++;
    end
  endtask

  task automatic wait_pin(input logic lv);
    for (int i = 0; i < 300 && pin_o[0] !== lv; i++) begin
      @(posedge mclk_i);
      #1;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk_i);
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    for (int i = 0; i < 10; i++) begin
      pwm(rows[i].md, rows[i].vl, {5'h03, rows[i].act, 2'h2}, rows[i].ps);
      repeat (4 * rows[i].per + 40) @(posedge mclk_i);
      chk("period", period, rows[i].per);
      chk("high", high, rows[i].hi);
    end
    do_reset;
    rd(4'h0);
    chk("ctl_rst", v, 16'h0020);
    rd(4'hF);
    chk("unmapped", v, 16'h0000);
    pwm(8'h03, 8'h01, 8'h1A, 3'h0);
    wr(4'h0, 8'h10);
    repeat (8) @(posedge mclk_i);
    chk("irq_off", {15'h0, irq_o}, 16'h0000);
    rd(4'h0);
    chk("wrap_flag", v, 16'h0080);
    wr(4'h0, 8'hC0);
    chk("irq_on", {15'h0, irq_o}, 16'h0001);
    wr(4'h0, 8'hE0);
    rd(4'h0);
    chk("flag_hold", v, 16'h00E0);
    wr(4'h0, 8'h60);
    rd(4'h0);
    chk("flag_clr", v, 16'h0060);
    rd(4'h5);
    chk("ch_flag", v, 16'h009A);
    wr(4'h5, 8'hDA);
    chk("ch_irq", {15'h0, irq_o}, 16'h0001);
    wr(4'h0, 8'h00);
    @(posedge mclk_i);
    wait_i <= 1'b1;
    wr(4'h3, 8'h55);
    rd(4'h3);
    chk("wait_rd", v, 16'h0000);
    hi_count;
    chk("wait_run", 16'(n), 16'h0010);
    chk("wait_irq", {15'h0, irq_o}, 16'h0001);
    @(posedge mclk_i);
    wait_i <= 1'b0;
    rd(4'h3);
    chk("wait_wr", v, 16'h0000);
    pwm(8'h0F, 8'h05, 8'h18, 3'h0);
    repeat (40) @(posedge mclk_i);
    hi_count;
    chk("zero_duty", 16'(n), 16'h0000);
    pwm(8'h0F, 8'h05, 8'h1B, 3'h0);
    repeat (40) @(posedge mclk_i);
    hi_count;
    chk("full_duty", 16'(n), 16'h0040);
    pwm(8'h0F, 8'h08, 8'h2A, 3'h0);
    repeat (80) @(posedge mclk_i);
    chk("link_hi", high, 16'h0008);
    chk("link_oe", {14'h0, pin_oe}, 16'h0001);
    wait_pin(1'b0);
    wait_pin(1'b1);
    wr(4'h9, 8'h00);
    wr(4'hA, 8'h03);
    wait_pin(1'b0);
    repeat (2) @(posedge mclk_i);
    chk("same_period", high, 16'h0008);
    repeat (40) @(posedge mclk_i);
    chk("ch1_takes", high, 16'h0003);
    wr(4'h8, 8'h3B);
    rd(4'h8);
    chk("ch1_ctl", v, 16'h001B);
    // the longer width goes in just after a wrap
    wait_pin(1'b0);
    wait_pin(1'b1);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h06);
    repeat (40) @(posedge mclk_i);
    chk("ch0_back", high, 16'h0006);
    // plain output compare toggling on compare, no wrap toggle
    pwm(8'h07, 8'h03, 8'h14, 3'h0);
    repeat (80) @(posedge mclk_i);
    chk("toggle_per", period, 16'h0010);
    chk("toggle_hi", high, 16'h0008);
    // channel 1 drives low while stopped, then releases its pin; the rise is captured
    do_reset;
    wr(4'h9, 8'h55);
    wr(4'h8, 8'h1C);
    wr(4'h8, 8'h04);
    repeat (4) @(posedge mclk_i);
    rd(4'h8);
    chk("cap_flag", v, 16'h0084);
    rd(4'h9);
    chk("cap_val", v, 16'h0000);
    tally_and_finish;
  end
endmodule  // timer_buffered_compare_pwm_tb

`default_nettype wire
